// *** verilog/lws_pkg.sv ***
package lws_pkg;

    // Data lane geometry.
    localparam int unsigned LANE_W     = 9;
    localparam int unsigned LANES      = 4;
    localparam int unsigned DATA_W     = LANE_W * LANES;
    localparam int unsigned ADDR_W     = 10;

    // Burst counter width and burst length.
    localparam int unsigned BURST_W    = 2;
    localparam int unsigned BURST_LEN  = 4;

    // Clock period of the controller side clock.
    localparam int unsigned CLK_PERIOD_NS = 50;

    // Static pin levels.
    localparam logic MODE_FLOW       = 1'b0;
    localparam logic ORDER_LINEAR    = 1'b0;

    // Reset values.
    localparam logic [BURST_W-1:0] BURST_RST  = 2'h0;
    localparam logic [LANES-1:0]   LANES_OFF  = 4'hF;

    // Operation carried by a burst.
    typedef enum logic [2:0] {
        LWS_OP_IDLE  = 3'b001,
        LWS_OP_READ  = 3'b010,
        LWS_OP_WRITE = 3'b100
    } lws_op_e;

endpackage

// *** verilog/lws_burst_ctr.sv ***
`timescale 1ns/1ns
module lws_burst_ctr (
    // Clock and reset.
    input  wire logic                            i_clk,
    input  wire logic                            i_srst,
    // Control.
    input  wire logic                            i_enable,
    input  wire logic                            i_load,
    input  wire logic                            i_step,
    input  wire logic [lws_pkg::BURST_W-1:0]     i_preset,
    input  wire logic                            i_linear_order_n,
    // Address of the access that a step would make.
    output logic      [lws_pkg::BURST_W-1:0]     o_step_low
);

    typedef struct packed {
        logic [lws_pkg::BURST_W-1:0] base;
        logic [lws_pkg::BURST_W-1:0] count;
    } lws_ctr_s;

    lws_ctr_s st_reg;
    lws_ctr_s st_next;

    // Linear adds the count to the base, interleaved XORs it in.
    function automatic logic [lws_pkg::BURST_W-1:0] burst_addr(
        input logic [lws_pkg::BURST_W-1:0] base,
        input logic [lws_pkg::BURST_W-1:0] count,
        input logic                        interleave
    );
        if (interleave) begin
            burst_addr = base ^ count; // R23 R18
        end else begin
            burst_addr = lws_pkg::BURST_W'(base + count); // R23 R18
        end
    endfunction

    logic [lws_pkg::BURST_W-1:0] count_inc;

    always_comb begin
        count_inc  = lws_pkg::BURST_W'(st_reg.count + 2'h1); // R21
        o_step_low = burst_addr(st_reg.base, count_inc, i_linear_order_n);
        st_next    = st_reg;
        if (i_enable && i_load) begin
            st_next.base  = i_preset; // R16
            st_next.count = lws_pkg::BURST_RST;
        end else if (i_enable && i_step) begin
            st_next.count = count_inc; // R15
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Four steps after a load come back to the loaded address.
    sequence s_load;
        i_enable && i_load;
    endsequence

    sequence s_four_steps;
        (i_enable && i_step && !i_load) [*4];
    endsequence

    property p_wrap;
        @(posedge i_clk) disable iff (i_srst)
        s_load ##1 s_four_steps |=> st_reg.count == lws_pkg::BURST_RST;
    endproperty

    burst_wrap_a: assert property (p_wrap) else $error("Burst count did not wrap."); // R21

    preset_load_a: assert property (@(posedge i_clk) disable iff (i_srst) // R16
        s_load |=> st_reg.base == $past(i_preset) && st_reg.count == lws_pkg::BURST_RST)
        else $error("Burst counter not preset on load.");

endmodule

// *** verilog/lws_sram_ctrl.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// R1: Clock enable high freezes all state.
// R2: Inputs sampled at edge except enable, order, sleep.
// R3: Controller loads new address with step low.
// R4: Selected only when all three selects active.
// R5: Read: selected, write high, load low.
// R6: Pipelined read data appears one edge later.
// R7: Write: selected, enabled, write enable low.
// R8: Each byte enable gates its 9-bit lane.
// R9: Write with no byte enable changes nothing.
// R10: Pipelined write data taken at third edge.
// R11: Flow-through read data follows address edge.
// R12: Flow-through write data taken at second edge.
// R13: Flow-through decode and bursts match pipelined mode.
// R14: Mode pin picks flow-through or pipelined.
// R15: Step high advances the burst counter.
// R16: Low address bits preset the burst counter.
// R17: Sleep forces outputs to high impedance.
// R18: Order pin low is linear, high interleaved.
// R19: Output enable high turns drivers off.
// R20: Mode pin low selects flow-through.
// R21: Burst counter wraps after four accesses.
// R22: Stall keeps read bus driven, write bus off.
// R23: Linear adds count, interleaved XORs it.
// R24: Drivers off while write data expected.
module lws_sram_ctrl #(
    parameter int unsigned ADDR_W = lws_pkg::ADDR_W
) (
    // Clock and reset.
    input  wire logic                          i_clk,
    input  wire logic                          i_srst,
    // Synchronous command inputs.
    input  wire logic                          i_clk_en_n,
    input  wire logic                          i_chip_sel_a_n,
    input  wire logic                          i_chip_sel_b,
    input  wire logic                          i_chip_sel_c_n,
    input  wire logic                          i_write_en_n,
    input  wire logic [lws_pkg::LANES-1:0]     i_byte_lane_en_n,
    input  wire logic                          i_load_or_step,
    input  wire logic [ADDR_W-1:0]             i_addr,
    // Static and asynchronous controls.
    input  wire logic                          i_out_en_n,
    input  wire logic                          i_sleep_req,
    input  wire logic                          i_latency_mode_sel,
    input  wire logic                          i_linear_order_n,
    // Data pins.
    input  wire logic [lws_pkg::DATA_W-1:0]    i_data,
    output logic      [lws_pkg::DATA_W-1:0]    o_data,
    output logic                               o_data_oe_n
);

    localparam int unsigned DW = lws_pkg::DATA_W;
    localparam int unsigned LN = lws_pkg::LANES;
    localparam int unsigned LW = lws_pkg::LANE_W;
    localparam int unsigned BW = lws_pkg::BURST_W;

    typedef struct packed {
        lws_pkg::lws_op_e  last_op;
        logic [ADDR_W-1:0] addr;
        logic              rd1_v;
        logic [DW-1:0]     rd1_data;
        logic              w1_v;
        logic [ADDR_W-1:0] w1_addr;
        logic [LN-1:0]     w1_be_n;
        logic              w2_v;
        logic [ADDR_W-1:0] w2_addr;
        logic [LN-1:0]     w2_be_n;
        logic              drive;
        logic [DW-1:0]     dout;
    } lws_state_s;

    localparam lws_state_s ST_RST = '{
        last_op:  lws_pkg::LWS_OP_IDLE,
        addr:     '0,
        rd1_v:    1'b0,
        rd1_data: '0,
        w1_v:     1'b0,
        w1_addr:  '0,
        w1_be_n:  lws_pkg::LANES_OFF,
        w2_v:     1'b0,
        w2_addr:  '0,
        w2_be_n:  lws_pkg::LANES_OFF,
        drive:    1'b0,
        dout:     '0
    };

    lws_state_s st_reg;
    lws_state_s st_next;

    logic [DW-1:0] mem [0:(1 << ADDR_W)-1];

    logic              active;
    logic              selected;
    logic              flow;
    logic              cmd_load;
    logic              cmd_step;
    logic              cmd_read;
    logic              cmd_write;
    logic              cmd_abort;
    logic [BW-1:0]     step_low;
    logic [ADDR_W-1:0] eff_addr;
    logic [DW-1:0]     rdata;
    logic              wr_fire;
    logic [ADDR_W-1:0] wr_addr;
    logic [LN-1:0]     wr_be_n;

    // A write is a real one when at least one lane is enabled.
    function automatic logic any_lane(input logic [LN-1:0] be_n);
        any_lane = (be_n != lws_pkg::LANES_OFF);
    endfunction

    lws_burst_ctr u_burst (
        .i_clk            (i_clk),
        .i_srst           (i_srst),
        .i_enable         (active),
        .i_load           (cmd_load),
        .i_step           (cmd_step),
        .i_preset         (i_addr[BW-1:0]),
        .i_linear_order_n (i_linear_order_n),
        .o_step_low       (step_low)
    );

    always_comb begin
        active   = !i_clk_en_n && !i_sleep_req; // R1 R17
        selected = !i_chip_sel_a_n && i_chip_sel_b && !i_chip_sel_c_n; // R4
        flow     = (i_latency_mode_sel == lws_pkg::MODE_FLOW); // R14 R20
        cmd_load = !i_load_or_step; // R3
        cmd_step = i_load_or_step; // R15
        // Decoding is shared by both latency modes.
        cmd_read  = cmd_load ? (selected && i_write_en_n) // R5 R13
                             : (st_reg.last_op == lws_pkg::LWS_OP_READ);
        cmd_write = cmd_load ? (selected && !i_write_en_n) // R7
                             : (st_reg.last_op == lws_pkg::LWS_OP_WRITE);
        cmd_abort = cmd_write && !any_lane(i_byte_lane_en_n); // R9
        eff_addr  = cmd_load ? i_addr // R16
                             : {st_reg.addr[ADDR_W-1:BW], step_low}; // R15
        rdata     = mem[eff_addr];
        // Flow-through writes take data one edge after the command.
        if (flow) begin
            wr_fire = active && st_reg.w1_v; // R12
            wr_addr = st_reg.w1_addr;
            wr_be_n = st_reg.w1_be_n;
        end else begin
            wr_fire = active && st_reg.w2_v; // R10
            wr_addr = st_reg.w2_addr;
            wr_be_n = st_reg.w2_be_n;
        end

        st_next = st_reg;
        if (active) begin
            if (cmd_load) begin
                if (cmd_read) begin
                    st_next.last_op = lws_pkg::LWS_OP_READ;
                end else if (cmd_write) begin
                    st_next.last_op = lws_pkg::LWS_OP_WRITE;
                end else begin
                    st_next.last_op = lws_pkg::LWS_OP_IDLE;
                end
            end
            st_next.addr     = eff_addr;
            st_next.rd1_v    = cmd_read;
            st_next.rd1_data = rdata;
            st_next.w1_v     = cmd_write && !cmd_abort; // R9
            st_next.w1_addr  = eff_addr;
            st_next.w1_be_n  = i_byte_lane_en_n;
            st_next.w2_v     = st_reg.w1_v && !flow;
            st_next.w2_addr  = st_reg.w1_addr;
            st_next.w2_be_n  = st_reg.w1_be_n;
            // Write data cycles never see the drivers on.
            if (flow) begin
                st_next.drive = cmd_read; // R11 R24
                st_next.dout  = rdata; // R11
            end else begin
                st_next.drive = st_reg.rd1_v; // R6 R24
                st_next.dout  = st_reg.rd1_data; // R6
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next; // R1 R22
        end
    end

    // Lane writes happen only where the byte enable is low.
    always_ff @(posedge i_clk) begin
        if (wr_fire) begin
            for (int l = 0; l < LN; l++) begin
                if (!wr_be_n[l]) begin
                    mem[wr_addr][l*LW +: LW] <= i_data[l*LW +: LW]; // R8
                end
            end
        end
    end

    // Output enable and sleep act at once on the drivers.
    assign o_data      = st_reg.dout;
    assign o_data_oe_n = !(st_reg.drive && !i_out_en_n && !i_sleep_req); // R17 R19 R2

    sequence s_go;
        !i_clk_en_n && !i_sleep_req;
    endsequence

    sequence s_new_read;
        s_go and (!i_load_or_step && selected && i_write_en_n);
    endsequence

    sequence s_new_write;
        s_go and (!i_load_or_step && selected && !i_write_en_n && any_lane(i_byte_lane_en_n));
    endsequence

    sequence s_flow_write;
        (flow and s_new_write) ##1 (flow and s_go);
    endsequence

    sequence s_pipe_write;
        (!flow and s_new_write) ##1 (!flow and s_go);
    endsequence

    stall_hold_a: assert property (@(posedge i_clk) disable iff (i_srst) // R1
        i_clk_en_n |=> $stable(st_reg))
        else $error("State changed on a stalled edge.");

    desel_idle_a: assert property (@(posedge i_clk) disable iff (i_srst) // R4
        s_go and (!i_load_or_step && !selected) |=> st_reg.last_op == lws_pkg::LWS_OP_IDLE
        && !st_reg.w1_v && !st_reg.rd1_v)
        else $error("Deselected cycle started an access.");

    flow_read_a: assert property (@(posedge i_clk) disable iff (i_srst) // R11
        flow and s_new_read |=> st_reg.drive && o_data == $past(rdata))
        else $error("Flow-through read data not driven after address edge.");

    pipe_read_a: assert property (@(posedge i_clk) disable iff (i_srst) // R6
        (!flow and s_new_read) ##1 (!flow and s_go)
        |=> st_reg.drive && o_data == $past(rdata, 2))
        else $error("Pipelined read data not on the second edge.");

    flow_write_a: assert property (@(posedge i_clk) disable iff (i_srst) // R12
        s_flow_write |-> wr_fire && wr_addr == $past(eff_addr))
        else $error("Flow-through write data not taken at the second edge.");

    pipe_write_a: assert property (@(posedge i_clk) disable iff (i_srst) // R10
        s_pipe_write ##1 (!flow and s_go) |-> wr_fire)
        else $error("Pipelined write data not taken at the third edge.");

    write_abort_a: assert property (@(posedge i_clk) disable iff (i_srst) // R9
        s_go and (!i_load_or_step && selected && !i_write_en_n
        && !any_lane(i_byte_lane_en_n)) |=> !st_reg.w1_v)
        else $error("Write with no lanes queued a write.");

    write_off_a: assert property (@(posedge i_clk) disable iff (i_srst) // R24
        flow and s_new_write |=> o_data_oe_n)
        else $error("Drivers on while write data expected.");

    oe_override_a: assert property (@(posedge i_clk) disable iff (i_srst) // R19
        i_out_en_n || i_sleep_req |-> o_data_oe_n)
        else $error("Drivers on while output enable or sleep forbids.");

    pipe_off_a: assert property (@(posedge i_clk) disable iff (i_srst) // R24
        s_pipe_write |=> o_data_oe_n)
        else $error("Drivers on in the pipelined write data slot.");

    slot_off_a: assert property (@(posedge i_clk) disable iff (i_srst) // R24 R22
        (flow && st_reg.w1_v) || st_reg.w2_v |-> o_data_oe_n)
        else $error("Drivers on while a write waits for its data.");

    load_addr_a: assert property (@(posedge i_clk) disable iff (i_srst) // R3
        s_go and !i_load_or_step |=> st_reg.addr == $past(i_addr))
        else $error("Loaded address not latched.");

    step_upper_a: assert property (@(posedge i_clk) disable iff (i_srst) // R15
        s_go and i_load_or_step
        |=> st_reg.addr[ADDR_W-1:BW] == $past(st_reg.addr[ADDR_W-1:BW]))
        else $error("Burst step changed the upper address bits.");

    lane_need_a: assert property (@(posedge i_clk) disable iff (i_srst) // R9
        wr_fire |-> any_lane(wr_be_n))
        else $error("Write fired with no lane enabled.");

    sleep_hold_a: assert property (@(posedge i_clk) disable iff (i_srst) // R17
        i_sleep_req |=> $stable(st_reg))
        else $error("State changed while asleep.");

    read_cont_a: assert property (@(posedge i_clk) disable iff (i_srst) // R13
        s_go and (i_load_or_step && st_reg.last_op == lws_pkg::LWS_OP_READ)
        |=> st_reg.rd1_v)
        else $error("Burst step after a read did not read.");

    desel_cont_a: assert property (@(posedge i_clk) disable iff (i_srst) // R4
        s_go and (i_load_or_step && st_reg.last_op == lws_pkg::LWS_OP_IDLE)
        |=> !st_reg.rd1_v && !st_reg.w1_v)
        else $error("Burst step after a deselect started an access.");

    write_start_a: assert property (@(posedge i_clk) disable iff (i_srst) // R7 R8
        s_new_write |=> st_reg.w1_v && st_reg.w1_be_n == $past(i_byte_lane_en_n))
        else $error("Write command not queued with its lanes.");

    read_stall_a: assert property (@(posedge i_clk) disable iff (i_srst) // R22
        st_reg.drive && i_clk_en_n |=> st_reg.drive)
        else $error("Read drivers dropped during a stall.");

endmodule

// *** verification/lws_ctrl_model.sv ***
`timescale 1ns/1ns
// Controller side of the data pins: holds write data back to the edge that takes it.
module lws_ctrl_model (
    // Clock, reset and pin state.
    input  wire logic                       i_clk,
    input  wire logic                       i_srst,
    input  wire logic                       i_clk_en_n,
    input  wire logic                       i_sleep_req,
    input  wire logic                       i_latency_mode_sel,
    // Write data offered with each write beat.
    input  wire logic                       i_wr_go,
    input  wire logic [lws_pkg::DATA_W-1:0] i_wr_data,
    // Data pins toward the memory.
    output logic      [lws_pkg::DATA_W-1:0] o_data
);
    logic                       go1_reg;
    logic                       go2_reg;
    logic [lws_pkg::DATA_W-1:0] d1_reg;
    logic [lws_pkg::DATA_W-1:0] d2_reg;
    logic [lws_pkg::DATA_W-1:0] junk_reg;

    always_ff @(posedge i_clk) begin
        junk_reg <= i_srst ? {lws_pkg::DATA_W{1'b0}} : ~o_data;
        if (i_srst) begin
            go1_reg <= 1'b0;
            go2_reg <= 1'b0;
        end else if (!i_clk_en_n && !i_sleep_req) begin
            go1_reg <= i_wr_go;
            d1_reg  <= i_wr_data;
            go2_reg <= go1_reg;
            d2_reg  <= d1_reg;
        end
    end

    // Outside its slot the bus shows a changing pattern, never stale data.
    always_comb begin
        if (i_latency_mode_sel == lws_pkg::MODE_FLOW && go1_reg) begin
            o_data = d1_reg;
        end else if (i_latency_mode_sel != lws_pkg::MODE_FLOW && go2_reg) begin
            o_data = d2_reg;
        end else begin
            o_data = junk_reg;
        end
    end
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    logic        clk, srst, clk_en_n, sel_a_n, sel_b, sel_c_n, we_n, step;
    logic        out_en_n, sleep, mode, order_n, oe_n, wr_go, act_reg;
    logic [3:0]  lanes_n;
    logic [9:0]  addr;
    logic [35:0] data_in, data_out, wr_data;
    logic [35:0] mem [0:1023];
    logic [35:0] exp_q [$];
    int          seed = 37478;
    int          err_total = 0;
    int          comparisons = 0;

    lws_sram_ctrl #(.ADDR_W(10)) DUT (
        .i_clk(clk), .i_srst(srst), .i_clk_en_n(clk_en_n), .i_chip_sel_a_n(sel_a_n),
        .i_chip_sel_b(sel_b), .i_chip_sel_c_n(sel_c_n), .i_write_en_n(we_n),
        .i_byte_lane_en_n(lanes_n), .i_load_or_step(step), .i_addr(addr),
        .i_out_en_n(out_en_n), .i_sleep_req(sleep), .i_latency_mode_sel(mode),
        .i_linear_order_n(order_n), .i_data(data_in), .o_data(data_out),
        .o_data_oe_n(oe_n));

    lws_ctrl_model PART (
        .i_clk(clk), .i_srst(srst), .i_clk_en_n(clk_en_n), .i_sleep_req(sleep),
        .i_latency_mode_sel(mode), .i_wr_go(wr_go), .i_wr_data(wr_data), .o_data(data_in));

    function automatic int unsigned rnd();
        return $unsigned($random(seed));
    endfunction

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Kind 0 read, 1 write with random lanes, 2 write of all lanes, 3 deselect.
    task automatic burst(input int kind, input logic [9:0] base, input int len);
        logic [1:0]  low;
        logic [9:0]  a;
        logic [3:0]  ln;
        logic [35:0] d;
        int unsigned r;
        for (int i = 0; i < len; i++) begin
            r   = rnd();
            low = order_n ? (base[1:0] ^ i[1:0]) : (base[1:0] + i[1:0]);
            a   = {base[9:2], low};
            d   = {r[3:0], rnd()};
            ln  = (kind == 2) ? 4'h0 : r[23:20];
            if (r[31:29] == 3'h0) begin
                @(posedge clk);
                clk_en_n <= 1'b1;
            end
            @(posedge clk);
            clk_en_n <= 1'b0;
            step     <= (i != 0);
            addr     <= (i == 0) ? base : r[13:4];
            sel_a_n  <= (i == 0) ? (kind == 3 && r[15:14] == 2'h0) : r[16];
            sel_b    <= (i == 0) ? !(kind == 3 && r[15:14] == 2'h1) : r[17];
            sel_c_n  <= (i == 0) ? (kind == 3 && r[15:14] >= 2'h2) : r[18];
            we_n     <= (i == 0 && kind != 3) ? (kind == 0) : r[19];
            lanes_n  <= ln;
            wr_go    <= (kind == 1 || kind == 2);
            wr_data  <= d;
            if (kind == 0) begin
                exp_q.push_back(mem[a]);
            end
            for (int l = 0; l < 4; l++) begin
                if ((kind == 1 || kind == 2) && !ln[l]) begin
                    mem[a][9*l +: 9] = d[9*l +: 9];
                end
            end
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        act_reg <= !srst && !clk_en_n && !sleep;
    end

    // A driven result after an active edge takes the oldest expected read.
    always @(negedge clk) begin
        if (act_reg && oe_n === 1'b0) begin
            if (exp_q.size() == 0) begin
                chk(36'(oe_n), 36'h1);
            end else begin
                chk(data_out, exp_q.pop_front());
            end
        end
    end

    initial begin
        #(50 * 20000);
        err_total++;
        conclude();
    end

    initial begin
        int unsigned r;
        int          k;
        srst = 1'b1; clk_en_n = 1'b0; sel_a_n = 1'b1; sel_b = 1'b0; sel_c_n = 1'b1;
        we_n = 1'b1; step = 1'b0; out_en_n = 1'b0; sleep = 1'b0; mode = 1'b0;
        order_n = 1'b0; lanes_n = 4'hF; addr = 10'h000; wr_go = 1'b0; wr_data = 36'h0;
        for (int run = 0; run < 4; run++) begin
            @(posedge clk);
            srst    <= 1'b1;
            mode    <= run[0];
            order_n <= run[1];
            repeat (5) @(posedge clk);
            srst <= 1'b0;
            @(negedge clk);
            chk(36'(oe_n), 36'h1);
            chk(data_out, 36'h0);
            for (int b = 0; b < 16; b++) begin
                burst(2, 10'(b * 4), 4);
            end
            burst(3, 10'h000, 2);
            repeat (40) begin
                r = rnd();
                k = int'(r[1:0]);
                burst(k, {4'h0, k == 0, r[6:2]}, 1 + int'(r[9:7] % 5));
            end
            burst(3, 10'h000, 3);
            for (int b = 0; b < 8; b++) begin
                burst(0, 10'(b * 4), 4);
            end
            burst(0, 10'h020, 1);
            if (mode) begin
                burst(3, 10'h000, 1);
            end
            @(posedge clk);
            clk_en_n <= 1'b1;
            @(negedge clk);
            chk(36'(oe_n), 36'h0);
            @(posedge clk);
            out_en_n <= 1'b1;
            @(negedge clk);
            chk(36'(oe_n), 36'h1);
            @(posedge clk);
            out_en_n <= 1'b0;
            sleep    <= 1'b1;
            @(negedge clk);
            chk(36'(oe_n), 36'h1);
            @(posedge clk);
            sleep <= 1'b0;
            @(negedge clk);
            chk(data_out, mem[10'h020]);
            burst(1, 10'h000, 1);
            @(posedge clk);
            clk_en_n <= 1'b1;
            @(negedge clk);
            chk(36'(oe_n), 36'h1);
            burst(3, 10'h000, 3);
        end
        repeat (3) @(posedge clk);
        chk(36'(exp_q.size()), 36'h0);
        conclude();
    end
endmodule
